/* hw/swc_switch_control.sv */
// Switch control register with reset triggers and unlock gates
`timescale 1ns/1ps
`default_nettype none
`include "swc_params.svh"
// What this block does
// - Writing one to fundamental reset trigger starts a whole-switch fundamental reset.
// - Writing one to hot reset trigger starts a switch hot reset unless a fundamental reset is also pending.
// - Software hot reset also makes the upstream port retrain its link.
// - Trigger bits ignore written zero and always read zero.
// - Completion of the triggering write is returned before the reset acts.
// - While register unlock is set, write-when-unlocked fields accept writes.
// - While register unlock is clear, write-when-unlocked fields are read-only.
// - Register unlock sets at start and hardware sets it again during every reset.
// - Power budget unlock set lets power budget values be read and written.
// - Power budget unlock clear makes power budget values read-only.
// - Link-down hot reset disable blocks hot reset on upstream link down.
// - That disable leaves every other hot reset cause working.
// - Power budget unlock and link-down disable keep their values through hot reset.
// - With power budget unlock clear, power budget writes are discarded.
module swc_switch_control
    import swc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hotResetIn,
    input  wire logic        upLinkDown,
    input  wire logic        otherHotReset,
    input  wire swc_req_t    cfgReq,
    input  wire logic        rwlWrite,
    input  wire logic [31:0] rwlWdata,
    output var  swc_cpl_t    cfgCpl,
    output var  logic        fundResetReq,
    output var  logic        hotResetReq,
    output var  logic        upLinkRetrain,
    output var  logic [31:0] rwlValue
);
    typedef struct packed {
        swc_state_t  state;
        logic [1:0]  wait_cnt;
        logic        pend_fund;
        logic        pend_hot;
        logic        reg_unlock;
        logic        pb_unlock;
        logic        ld_hr_dis;
        logic        cpl_valid;
        logic [31:0] cpl_data;
        logic        fund_req;
        logic        hot_req;
        logic        retrain;
        logic        rd_pend;
    } swc_state_s_t;

    swc_state_s_t s_q;
    swc_state_s_t s_d;

    logic        ctlHit;
    logic        pbHit;
    logic        pbWe;
    logic [2:0]  pbIdx;
    logic [31:0] pbRdata;
    logic [31:0] ctlRead;
    logic        anyReset;

    assign ctlHit   = cfgReq.valid && cfgReq.addr == `SWC_CTL_OFFSET;
    assign pbHit    = cfgReq.valid && cfgReq.addr >= `SWC_PBDV_BASE && cfgReq.addr <= `SWC_PBDV_LAST
                      && cfgReq.addr[1:0] == 2'h0;
    assign pbIdx    = cfgReq.addr[4:2];
    assign pbWe     = pbHit && cfgReq.write && s_q.pb_unlock;
    assign anyReset = s_q.fund_req || s_q.hot_req || hotResetIn;

    // Read view: triggers and reserved bit always zero
    always_comb
    begin
        ctlRead = 32'h00000000;
        ctlRead[`SWC_BIT_REG_UNLOCK] = s_q.reg_unlock;
        ctlRead[`SWC_BIT_PB_UNLOCK]  = s_q.pb_unlock;
        ctlRead[`SWC_BIT_LD_HR_DIS]  = s_q.ld_hr_dis;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.cpl_valid = 1'b0;
        s_d.fund_req  = 1'b0;
        s_d.hot_req   = 1'b0;
        s_d.retrain   = 1'b0;
        s_d.rd_pend   = 1'b0;
        if (s_q.rd_pend)
        begin
            s_d.cpl_valid = 1'b1;
            s_d.cpl_data  = pbRdata;
        end
        else if (ctlHit)
        begin
            s_d.cpl_valid = 1'b1;
            s_d.cpl_data  = cfgReq.write ? 32'h00000000 : ctlRead;
            if (cfgReq.write)
            begin
                s_d.reg_unlock = cfgReq.wdata[`SWC_BIT_REG_UNLOCK];
                s_d.ld_hr_dis  = cfgReq.wdata[`SWC_BIT_LD_HR_DIS];
                if (s_q.reg_unlock)
                    s_d.pb_unlock = cfgReq.wdata[`SWC_BIT_PB_UNLOCK];
                if (cfgReq.wdata[`SWC_BIT_FUND_RESET])
                    s_d.pend_fund = 1'b1;
                if (cfgReq.wdata[`SWC_BIT_HOT_RESET])
                    s_d.pend_hot = 1'b1;
            end
        end
        else if (pbHit)
        begin
            if (cfgReq.write)
            begin
                s_d.cpl_valid = 1'b1;
                s_d.cpl_data  = 32'h00000000;
            end
            else
                s_d.rd_pend = 1'b1;
        end
        else if (cfgReq.valid)
        begin
            s_d.cpl_valid = 1'b1;
            s_d.cpl_data  = 32'h00000000;
        end
        case (s_q.state)
            SWC_IDLE:
            begin
                if (s_d.pend_fund || s_d.pend_hot)
                begin
                    s_d.state    = SWC_WAIT_CPL;
                    s_d.wait_cnt = 2'(`SWC_CPL_DELAY);
                end
            end
            SWC_WAIT_CPL:
            begin
                // Completion goes out before the reset fires
                if (s_q.wait_cnt == 2'h1)
                    s_d.state = SWC_FIRE;
                s_d.wait_cnt = s_q.wait_cnt - 2'h1;
            end
            SWC_FIRE:
            begin
                s_d.fund_req  = s_q.pend_fund;
                s_d.hot_req   = s_q.pend_hot && !s_q.pend_fund;
                s_d.retrain   = s_q.pend_hot && !s_q.pend_fund;
                s_d.pend_fund = 1'b0;
                s_d.pend_hot  = 1'b0;
                s_d.state     = SWC_IDLE;
            end
            default: s_d.state = SWC_IDLE;
        endcase
        // While idle with nothing pending, link down resets only when not disabled; other causes always pass
        if (s_q.state == SWC_IDLE && !s_d.pend_fund && !s_d.pend_hot)
        begin
            if (upLinkDown && !s_q.ld_hr_dis)
                s_d.hot_req = 1'b1;
            if (otherHotReset)
                s_d.hot_req = 1'b1;
        end
        // Sticky fields kept through hot reset; unlock reopened by every reset
        if (anyReset)
            s_d.reg_unlock = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q           <= '0;
            s_q.state     <= SWC_IDLE;
            s_q.reg_unlock <= 1'b1;
            s_q.pb_unlock <= `SWC_CTL_RESET;
            s_q.ld_hr_dis <= `SWC_CTL_RESET;
        end
        else
            s_q <= s_d;
    end

    swc_pbdv_mem #(
        .DEPTH (8)
    ) u_pbdv (
        .clk   (clk),
        .rst   (rst),
        .we    (pbWe),
        .addr  (pbIdx),
        .wdata (cfgReq.wdata),
        .rdata (pbRdata)
    );

    swc_lock_field #(
        .WIDTH (32)
    ) u_rwl (
        .clk    (clk),
        .rst    (rst),
        .unlock (s_q.reg_unlock),
        .we     (rwlWrite),
        .wdata  (rwlWdata),
        .value  (rwlValue)
    );

    assign cfgCpl.valid  = s_q.cpl_valid;
    assign cfgCpl.rdata  = s_q.cpl_data;
    assign fundResetReq  = s_q.fund_req;
    assign hotResetReq   = s_q.hot_req;
    assign upLinkRetrain = s_q.retrain;

    a_trig_read_zero: assert property (@(posedge clk) disable iff (rst)
        ctlHit && !cfgReq.write && !s_q.rd_pend |=> cfgCpl.valid && cfgCpl.rdata[1:0] == 2'h0)
        else $error("trigger bits read nonzero");
    a_rsv_read_zero: assert property (@(posedge clk) disable iff (rst)
        ctlHit && !cfgReq.write && !s_q.rd_pend |=> cfgCpl.rdata[2] == 1'b0)
        else $error("reserved bit read nonzero");
    sequence s_fund_write;
        ctlHit && cfgReq.write && cfgReq.wdata[0] && !s_q.rd_pend && s_q.state == SWC_IDLE;
    endsequence
    a_fund_fires: assert property (@(posedge clk) disable iff (rst)
        s_fund_write |-> ##[1:5] fundResetReq)
        else $error("fundamental reset not raised");
    a_cpl_first: assert property (@(posedge clk) disable iff (rst)
        s_fund_write |=> cfgCpl.valid && !fundResetReq)
        else $error("reset before completion");
    a_hot_retrain: assert property (@(posedge clk) disable iff (rst)
        hotResetReq && !upLinkDown |-> 1'b1 ##0 (upLinkRetrain || $past(otherHotReset) || $past(upLinkDown)))
        else $error("hot reset without retrain");
    a_hot_fires: assert property (@(posedge clk) disable iff (rst)
        ctlHit && cfgReq.write && cfgReq.wdata[1] && !cfgReq.wdata[0] && !s_q.rd_pend
        && s_q.state == SWC_IDLE && !s_q.pend_fund |-> ##[1:5] upLinkRetrain)
        else $error("hot reset not raised");
    a_ld_disable: assert property (@(posedge clk) disable iff (rst)
        s_q.ld_hr_dis && !otherHotReset && s_q.state == SWC_IDLE && !s_d.pend_hot && !s_d.pend_fund
        |=> !hotResetReq)
        else $error("link down hot reset while disabled");
    a_pb_locked: assert property (@(posedge clk) disable iff (rst)
        pbHit && cfgReq.write && !s_q.pb_unlock |-> !pbWe)
        else $error("power budget write while locked");
    a_unlock_on_rst: assert property (@(posedge clk) disable iff (rst)
        hotResetIn |=> s_q.reg_unlock)
        else $error("unlock not set by reset");

    // Link causes are only taken while idle and nothing is pending
    logic causeWindow;
    assign causeWindow = s_q.state == SWC_IDLE && !s_d.pend_hot && !s_d.pend_fund;

    sequence s_hot_write;
        ctlHit && cfgReq.write && cfgReq.wdata[1] && !cfgReq.wdata[0] && !s_q.rd_pend && s_q.state == SWC_IDLE;
    endsequence
    sequence s_zero_write;
        ctlHit && cfgReq.write && cfgReq.wdata[1:0] == 2'h0 && !s_q.rd_pend && s_q.state == SWC_IDLE;
    endsequence
    sequence s_rwl_locked_write;
        rwlWrite && !s_q.reg_unlock;
    endsequence
    sequence s_rwl_open_write;
        rwlWrite && s_q.reg_unlock;
    endsequence

    a_hot_cpl_first: assert property (@(posedge clk) disable iff (rst)
        s_hot_write |=> cfgCpl.valid && !hotResetReq)
        else $error("hot reset before completion");
    a_hot_pulse: assert property (@(posedge clk) disable iff (rst)
        s_hot_write |-> ##[1:5] hotResetReq)
        else $error("hot reset pulse missing");
    a_retrain_hot: assert property (@(posedge clk) disable iff (rst)
        upLinkRetrain |-> hotResetReq)
        else $error("retrain without hot reset");
    a_fund_no_retrain: assert property (@(posedge clk) disable iff (rst)
        fundResetReq |-> !upLinkRetrain)
        else $error("retrain with fundamental reset");
    a_zero_no_fund: assert property (@(posedge clk) disable iff (rst)
        s_zero_write |=> (!fundResetReq) [*4])
        else $error("zero write raised fundamental reset");
    a_zero_no_retrain: assert property (@(posedge clk) disable iff (rst)
        s_zero_write |=> (!upLinkRetrain) [*4])
        else $error("zero write raised retrain");
    a_wr_cpl_zero: assert property (@(posedge clk) disable iff (rst)
        ctlHit && cfgReq.write && !s_q.rd_pend |=> cfgCpl.valid && cfgCpl.rdata == 32'h00000000)
        else $error("control write completion missing");
    a_rwl_hold: assert property (@(posedge clk) disable iff (rst)
        s_rwl_locked_write |=> $stable(rwlValue))
        else $error("locked field changed");
    a_rwl_update: assert property (@(posedge clk) disable iff (rst)
        s_rwl_open_write |=> rwlValue == $past(rwlWdata))
        else $error("unlocked field not written");
    a_pb_open: assert property (@(posedge clk) disable iff (rst)
        pbHit && cfgReq.write && s_q.pb_unlock |-> pbWe)
        else $error("power budget write dropped while unlocked");
    a_pb_rd_cpl: assert property (@(posedge clk) disable iff (rst)
        pbHit && !cfgReq.write && !s_q.rd_pend |-> ##2 cfgCpl.valid)
        else $error("power budget read completion missing");
    a_pb_gate_kept: assert property (@(posedge clk) disable iff (rst)
        ctlHit && cfgReq.write && !s_q.reg_unlock && !s_q.rd_pend |=> $stable(s_q.pb_unlock))
        else $error("power budget unlock changed while locked");
    a_ld_enabled: assert property (@(posedge clk) disable iff (rst)
        upLinkDown && !s_q.ld_hr_dis && causeWindow |=> hotResetReq)
        else $error("link down hot reset missing");
    a_other_cause: assert property (@(posedge clk) disable iff (rst)
        otherHotReset && causeWindow |=> hotResetReq)
        else $error("other hot reset cause lost");
    a_sticky_hold: assert property (@(posedge clk) disable iff (rst)
        hotResetIn && !ctlHit |=> $stable(s_q.pb_unlock) && $stable(s_q.ld_hr_dis))
        else $error("sticky bit lost on hot reset");
endmodule : swc_switch_control
`default_nettype wire

/* hw/swc_params.svh */
// Offsets, field positions, reset values and timing counts of the switch control register
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH
`define SWC_CTL_OFFSET       12'h404
`define SWC_PBDV_BASE        12'h300
`define SWC_PBDV_LAST        12'h31C
`define SWC_BIT_FUND_RESET   0
`define SWC_BIT_HOT_RESET    1
`define SWC_BIT_RESERVED     2
`define SWC_BIT_REG_UNLOCK   3
`define SWC_BIT_PB_UNLOCK    4
`define SWC_BIT_LD_HR_DIS    5
`define SWC_CTL_RESET        1'b0
`define SWC_PBDV_RESET       32'h00000000
`define SWC_CPL_DELAY        2
`endif

/* hw/swc_pkg.sv */
// Types shared by the switch control register files
package swc_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } swc_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } swc_cpl_t;

    typedef enum logic [1:0] {
        SWC_IDLE,
        SWC_WAIT_CPL,
        SWC_FIRE
    } swc_state_t;
endpackage : swc_pkg

/* hw/swc_pbdv_mem.sv */
// Power budget data value word store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "swc_params.svh"
module swc_pbdv_mem
    import swc_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] addr,
    input  wire logic [31:0]              wdata,
    output var  logic [31:0]              rdata
);
    logic [31:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= `SWC_PBDV_RESET;
            rdata <= `SWC_PBDV_RESET;
        end
        else
        begin
            if (we)
                mem[addr] <= wdata;
            rdata <= mem[addr];
        end
    end
endmodule : swc_pbdv_mem
`default_nettype wire

/* hw/swc_lock_field.sv */
// One write-when-unlocked field
`timescale 1ns/1ps
`default_nettype none
`include "swc_params.svh"
module swc_lock_field
    import swc_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             unlock,
    input  wire logic             we,
    input  wire logic [WIDTH-1:0] wdata,
    output var  logic [WIDTH-1:0] value
);
    always_ff @(posedge clk)
    begin
        if (rst)
            value <= '0;
        else if (we && unlock)
            value <= wdata;
    end
endmodule : swc_lock_field
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking testbench for the switch control register
`timescale 1ns/1ps
`default_nettype none
`include "swc_params.svh"
module tb_top
    import swc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hotResetIn = 1'b0;
    logic        upLinkDown = 1'b0;
    logic        otherHotReset = 1'b0;
    swc_req_t    cfgReq = '0;
    logic        rwlWrite = 1'b0;
    logic [31:0] rwlWdata = 32'h0;
    swc_cpl_t    cfgCpl;
    logic        fundResetReq;
    logic        hotResetReq;
    logic        upLinkRetrain;
    logic [31:0] rwlValue;
    int          mismatches = 0;
    int          checks = 0;
    logic [31:0] rd;
    int          f;
    int          h;
    int          r;

    always #2.5 clk = ~clk;

    swc_switch_control i_dut (.clk(clk), .rst(rst), .hotResetIn(hotResetIn), .upLinkDown(upLinkDown),
        .otherHotReset(otherHotReset), .cfgReq(cfgReq), .rwlWrite(rwlWrite), .rwlWdata(rwlWdata),
        .cfgCpl(cfgCpl), .fundResetReq(fundResetReq), .hotResetReq(hotResetReq),
        .upLinkRetrain(upLinkRetrain), .rwlValue(rwlValue));

    task automatic results();
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One configuration request, returns the completion data
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cfgReq <= '{valid: 1'b1, write: w, addr: a, wdata: d};
        @(posedge clk);
        cfgReq <= '0;
        #1;
        while (cfgCpl.valid !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 4)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, cfgCpl.valid, 1'b1);
            results();
        end
        else
            q = cfgCpl.rdata;
    endtask : access

    // First cycle offset of each reset pulse, -1 when absent
    task automatic watch(output int fo, output int ho, output int ro);
        fo = -1;
        ho = -1;
        ro = -1;
        for (int i = 0; i <= 6; i++)
        begin
            if (i > 0)
                @(posedge clk);
            #1;
            if (fundResetReq === 1'b1 && fo < 0) fo = i;
            if (hotResetReq === 1'b1 && ho < 0) ho = i;
            if (upLinkRetrain === 1'b1 && ro < 0) ro = i;
        end
    endtask : watch

    task automatic pulse_in(input int sel);
        @(posedge clk);
        if (sel == 0) upLinkDown <= 1'b1;
        else if (sel == 1) otherHotReset <= 1'b1;
        else hotResetIn <= 1'b1;
        @(posedge clk);
        upLinkDown <= 1'b0;
        otherHotReset <= 1'b0;
        hotResetIn <= 1'b0;
    endtask : pulse_in

    task automatic rwl_write(input logic [31:0] d);
        @(posedge clk);
        rwlWrite <= 1'b1;
        rwlWdata <= d;
        @(posedge clk);
        rwlWrite <= 1'b0;
        @(posedge clk);
        #1;
    endtask : rwl_write

    // Reset value, unlock set and reserved bits zero
    task automatic scn_reset_value();
        access(1'b0, 12'h404, 32'h0, rd);
        chk(rd, 32'h00000008);
        access(1'b0, 12'h200, 32'h0, rd);
        chk(rd, 32'h00000000);
    endtask : scn_reset_value

    // Write-when-unlocked field follows the unlock bit
    task automatic scn_rwl();
        rwl_write(32'h12345678);
        chk(rwlValue, 32'h12345678);
        access(1'b1, 12'h404, 32'h00000000, rd);
        rwl_write(32'hA5A5A5A5);
        chk(rwlValue, 32'h12345678);
        access(1'b1, 12'h404, 32'h00000010, rd);
        access(1'b0, 12'h404, 32'h0, rd);
        chk(rd, 32'h00000000);
        access(1'b1, 12'h404, 32'h00000008, rd);
    endtask : scn_rwl

    // Software triggers: completion first, pulse three cycles later, read zero
    task automatic scn_triggers();
        access(1'b1, 12'h404, 32'h0000000D, rd);
        watch(f, h, r);
        chk(32'(f), 32'(`SWC_CPL_DELAY + 1));
        chk(32'(r), 32'hFFFFFFFF);
        access(1'b0, 12'h404, 32'h0, rd);
        chk(rd, 32'h00000008);
        access(1'b1, 12'h404, 32'h0000000A, rd);
        watch(f, h, r);
        chk(32'(h), 32'(`SWC_CPL_DELAY + 1));
        chk(32'(r), 32'(`SWC_CPL_DELAY + 1));
        chk(32'(f), 32'hFFFFFFFF);
        access(1'b0, 12'h404, 32'h0, rd);
        chk(rd, 32'h00000008);
    endtask : scn_triggers

    // Power budget words writable only while unlocked
    task automatic scn_power_budget();
        access(1'b1, 12'h404, 32'h00000018, rd);
        access(1'b1, 12'h31C, 32'hCAFE0001, rd);
        access(1'b0, 12'h31C, 32'h0, rd);
        chk(rd, 32'hCAFE0001);
        access(1'b1, 12'h404, 32'h00000008, rd);
        access(1'b1, 12'h31C, 32'h0000BEEF, rd);
        access(1'b0, 12'h31C, 32'h0, rd);
        chk(rd, 32'hCAFE0001);
    endtask : scn_power_budget

    // Link-down hot reset disable and other causes
    task automatic scn_link_down();
        pulse_in(0);
        watch(f, h, r);
        chk(32'(h), 32'h0);
        access(1'b1, 12'h404, 32'h00000038, rd);
        pulse_in(0);
        watch(f, h, r);
        chk(32'(h), 32'hFFFFFFFF);
        pulse_in(1);
        watch(f, h, r);
        chk(32'(h), 32'h0);
        access(1'b1, 12'h404, 32'h00000022, rd);
        watch(f, h, r);
        chk(32'(h), 32'(`SWC_CPL_DELAY + 1));
    endtask : scn_link_down

    // Hot reset keeps sticky bits and sets unlock
    task automatic scn_hot_reset_in();
        access(1'b1, 12'h404, 32'h00000030, rd);
        access(1'b0, 12'h404, 32'h0, rd);
        chk(rd, 32'h00000030);
        pulse_in(2);
        repeat (3) @(posedge clk);
        access(1'b0, 12'h404, 32'h0, rd);
        chk(rd, 32'h00000038);
    endtask : scn_hot_reset_in

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        scn_reset_value();
        scn_rwl();
        scn_triggers();
        scn_power_budget();
        scn_link_down();
        scn_hot_reset_in();
        results();
    end
endmodule : tb_top
`default_nettype wire
